// File: frsd_pkg.sv
// Package for the fine reference switch decoder: counter layout, widths and reset values.
// Assumes the angle counter is clocked by the same ref_clk as the decoder.
package frsd_pkg;

    // Width of the angle counter that steers the fine converter switches.
    localparam int CNT_W = 12;
    // Number of ladder switches, fed from the low counter stages.
    localparam int LADDER_W = 7;
    localparam int LADDER_LSB = 0;
    // Number of fixed attenuation switches and the width of their index.
    localparam int ATTEN_N = 4;
    localparam int ATTEN_IDX_W = 2;

    // Counter stage positions.
    localparam int BIT_HALF_SEG = 7;
    localparam int BIT_SEG_LO = 8;
    localparam int BIT_SEG_HI = 9;
    localparam int BIT_QUAD_90 = 10;
    localparam int BIT_QUAD_180 = 11;

    // Sub-fields used to recognise particular angle spans.
    localparam int SPAN_W = 3;
    localparam logic [SPAN_W-1:0] SPAN_FIRST = 3'h0;
    localparam logic [SPAN_W-1:0] SPAN_SECOND = 3'h1;
    localparam logic [SPAN_W-1:0] SPAN_LAST = 3'h7;

    // Reset state matches a counter reading of zero degrees.
    localparam logic [ATTEN_N-1:0] ATTEN_RST = 4'h1;
    localparam logic [LADDER_W-1:0] LADDER_RST = 7'h00;
    localparam logic COS_BIT_RST = 1'b1;
    localparam logic S2C_RST = 1'b1;

    typedef enum logic [1:0]
    {
        QUAD_I,
        QUAD_II,
        QUAD_III,
        QUAD_IV
    } frsd_quad_type;

    // Quadrant from the 90 and 180 degree stages.
    function automatic frsd_quad_type frsd_quad_of(input logic [CNT_W-1:0] cnt);
        frsd_quad_type q;
        q = QUAD_I;
        case ({cnt[BIT_QUAD_180], cnt[BIT_QUAD_90]})
            2'h0: q = QUAD_I;
            2'h1: q = QUAD_II;
            2'h2: q = QUAD_III;
            2'h3: q = QUAD_IV;
            default: q = QUAD_I;
        endcase
        return q;
    endfunction

endpackage

// File: frsd_onehot_dec.sv
// One-hot decoder used for the fixed attenuation choice.
// Assumes a binary index; output is combinational and registered by the caller.
`timescale 1ns/10ps
module frsd_onehot_dec #(
    parameter int SEL_W = 2,
    parameter int OUT_N = 4
)
(
    // Index in.
    input wire logic [SEL_W-1:0] sel,
    // One-hot out.
    output logic [OUT_N-1:0] onehot
);

    genvar gi;
    generate
        for (gi = 0; gi < OUT_N; gi = gi + 1)
        begin : g_dec
            assign onehot[gi] = (sel == SEL_W'(gi));
        end
    endgenerate

endmodule // frsd_onehot_dec

// File: frsd_switch_decode.sv
// Decodes the angle counter into the fine converter's analog switch enables.
// Assumes angle_count comes from the counter on ref_clk, so it is used without synchronisers.
//
// Function
// - Exactly one of the four reference-output enables is high at all times.
// - The two cross-feed enables are never high together.
// - Sine-to-cosine cross-feed in quadrants I and III, the other in II and IV.
// - In quadrants II and IV the sine-side outputs alternate with counter bit 7.
// - In quadrants I and III the cosine-side outputs alternate with counter bit 7.
// - First sine-side and cosine-side outputs feed the -11.25 degree bit signal.
// - Second sine-side and cosine-side outputs feed the bias signal instead.
// - Seven ladder enables follow counter bits 0 through 6 directly.
// - The four attenuation selects are one-hot for every counter value.
// - Bit 10 means 90 degrees and bit 11 means 180 degrees.
// - Quadrant I uses the cosine bit output to 11.25 degrees, then the bias one.
`timescale 1ns/10ps
module frsd_switch_decode
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Angle counter.
    input wire logic [frsd_pkg::CNT_W-1:0] angle_count,
    // Fixed attenuation and ladder switches.
    output logic [frsd_pkg::ATTEN_N-1:0] attenuation_pair_selects,
    output logic [frsd_pkg::LADDER_W-1:0] ladder_switch_enables,
    // Reference generator switches.
    output logic sine_out_bit_select,
    output logic sine_out_bias_select,
    output logic sine_to_cos_crossfeed,
    output logic cos_out_bit_select,
    output logic cos_out_bias_select,
    output logic cos_to_sine_crossfeed,
    // Signal routed to the main summing module, and the decoded quadrant.
    output logic main_summing_bit_active,
    output logic main_summing_bias_active,
    output frsd_pkg::frsd_quad_type quadrant
);
    import frsd_pkg::*;

    logic quad_odd;
    logic half_seg;
    logic [ATTEN_IDX_W-1:0] atten_idx;
    logic [ATTEN_N-1:0] atten_nxt;

    // In quadrants II and IV the attenuation order runs backwards, so the
    // segment bits are inverted there to keep the sine and cosine pairing.
    assign quad_odd = angle_count[BIT_QUAD_90];
    assign half_seg = angle_count[BIT_HALF_SEG];
    assign atten_idx = {angle_count[BIT_SEG_HI], angle_count[BIT_SEG_LO]} ^ {quad_odd, quad_odd};

    frsd_onehot_dec #(
        .SEL_W(ATTEN_IDX_W),
        .OUT_N(ATTEN_N)
    ) u_atten_dec (
        .sel(atten_idx),
        .onehot(atten_nxt)
    );

    // All enables are registered so that switch drivers never see decode glitches.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            attenuation_pair_selects <= ATTEN_RST;
        end
        else
        begin
            attenuation_pair_selects <= atten_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ladder_switch_enables <= LADDER_RST;
        end
        else
        begin
            ladder_switch_enables <= angle_count[LADDER_LSB +: LADDER_W];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sine_to_cos_crossfeed <= S2C_RST;
            cos_to_sine_crossfeed <= !S2C_RST;
        end
        else
        begin
            sine_to_cos_crossfeed <= !quad_odd;
            cos_to_sine_crossfeed <= quad_odd;
        end
    end

    // Exactly one of the four outputs is chosen by quadrant parity and bit 7.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sine_out_bit_select <= !COS_BIT_RST;
            sine_out_bias_select <= !COS_BIT_RST;
            cos_out_bit_select <= COS_BIT_RST;
            cos_out_bias_select <= !COS_BIT_RST;
        end
        else
        begin
            sine_out_bit_select <= quad_odd && !half_seg;
            sine_out_bias_select <= quad_odd && half_seg;
            cos_out_bit_select <= !quad_odd && !half_seg;
            cos_out_bias_select <= !quad_odd && half_seg;
        end
    end

    // The summing junction sees the bit signal whenever bit 7 is clear.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            main_summing_bit_active <= COS_BIT_RST;
            main_summing_bias_active <= !COS_BIT_RST;
        end
        else
        begin
            main_summing_bit_active <= !half_seg;
            main_summing_bias_active <= half_seg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quadrant <= QUAD_I;
        end
        else
        begin
            quadrant <= frsd_quad_of(angle_count);
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_ref_out_onehot: assert property (
        $onehot({sine_out_bit_select, sine_out_bias_select, cos_out_bit_select,
            cos_out_bias_select}))
        else $error("Reference output enables are not one-hot.");

    a_crossfeed_exclusive: assert property (
        !(sine_to_cos_crossfeed && cos_to_sine_crossfeed)
            && (sine_to_cos_crossfeed || cos_to_sine_crossfeed))
        else $error("Cross-feed enables overlap or are both off.");

    a_crossfeed_quadrant: assert property (
        angle_count[BIT_QUAD_90] |=> cos_to_sine_crossfeed && !sine_to_cos_crossfeed
            && (quadrant == QUAD_II || quadrant == QUAD_IV))
        else $error("Wrong cross-feed in quadrant II or IV.");

    a_sine_side_alt: assert property (
        (angle_count[BIT_QUAD_90] && angle_count[BIT_HALF_SEG])
            ##1 (angle_count[BIT_QUAD_90] && !angle_count[BIT_HALF_SEG])
            |=> sine_out_bit_select && $fell(sine_out_bias_select))
        else $error("Sine-side outputs did not alternate with bit 7.");

    a_cos_side_alt: assert property (
        !angle_count[BIT_QUAD_90] |=> sine_to_cos_crossfeed
            && (cos_out_bias_select == $past(angle_count[BIT_HALF_SEG]))
            && (cos_out_bit_select == !$past(angle_count[BIT_HALF_SEG])))
        else $error("Cosine-side output does not follow bit 7.");

    a_bit_signal_route: assert property (
        !angle_count[BIT_HALF_SEG] |=> main_summing_bit_active && !main_summing_bias_active
            && (sine_out_bit_select || cos_out_bit_select))
        else $error("Bit signal not routed while bit 7 is clear.");

    a_bias_signal_route: assert property (
        angle_count[BIT_HALF_SEG] |=> main_summing_bias_active && !main_summing_bit_active
            && (sine_out_bias_select || cos_out_bias_select))
        else $error("Bias signal not routed while bit 7 is set.");

    a_ladder_follow: assert property (
        1'b1 |=> ladder_switch_enables == $past(angle_count[LADDER_LSB +: LADDER_W]))
        else $error("Ladder enables do not follow the low counter stages.");

    a_atten_onehot: assert property (
        $onehot(attenuation_pair_selects))
        else $error("Attenuation selects are not one-hot.");

    a_atten_ends: assert property (
        (angle_count[BIT_QUAD_90 -: SPAN_W] == SPAN_FIRST
            || angle_count[BIT_QUAD_90 -: SPAN_W] == SPAN_LAST)
            |=> attenuation_pair_selects[0])
        else $error("Smallest attenuation not chosen next to a quadrant edge.");

    a_quad_weights: assert property (
        (angle_count[BIT_QUAD_180] && !angle_count[BIT_QUAD_90]) |=> quadrant == QUAD_III)
        else $error("Quadrant decode does not treat bits 11 and 10 as 180 and 90.");

    a_first_span: assert property (
        (!angle_count[BIT_QUAD_180] && angle_count[BIT_QUAD_90 -: SPAN_W + 1] == 4'h0)
            |=> cos_out_bit_select ##0 !cos_out_bias_select)
        else $error("Quadrant I first span must use the cosine bit output.");

    a_second_span: assert property (
        (!angle_count[BIT_QUAD_180]
            && angle_count[BIT_QUAD_90 -: SPAN_W + 1] == {1'b0, SPAN_SECOND})
            |=> cos_out_bias_select && !cos_out_bit_select)
        else $error("Quadrant I second span must use the cosine bias output.");

    a_sine_polarity: assert property (
        (angle_count[BIT_QUAD_90] && !angle_count[BIT_HALF_SEG]) |=> sine_out_bit_select)
        else $error("Sine bit output not chosen with bit 7 clear.");

    c_quad_change: cover property (
        (quadrant == QUAD_I) ##1 (quadrant == QUAD_II));
    c_crossfeed_swap: cover property (
        $rose(cos_to_sine_crossfeed) && $fell(sine_to_cos_crossfeed));
    c_bias_toggle: cover property (
        $rose(sine_out_bias_select) ##[1:300] $fell(sine_out_bias_select));
    c_wrap_around: cover property (
        (quadrant == QUAD_IV) ##1 (quadrant == QUAD_I));

endmodule // frsd_switch_decode

// File: frsd_switch_net_model.sv
// Behavioural model of the analog switch network fed by the switch decoder.
// Assumes level enables, active high, straight from the decoder outputs.
`timescale 1ns/10ps
module frsd_switch_net_model
(
    // Reference generator switches.
    input wire logic sine_out_bit_select,
    input wire logic sine_out_bias_select,
    input wire logic sine_to_cos_crossfeed,
    input wire logic cos_out_bit_select,
    input wire logic cos_out_bias_select,
    input wire logic cos_to_sine_crossfeed,
    // Observed state of the network.
    output logic [2:0] ref_path_count,
    output logic feed_clash
);
    // Count of amplifier outputs reaching the ladder amplifier; anything but one is a fault.
    assign ref_path_count = 3'(sine_out_bit_select) + 3'(sine_out_bias_select)
        + 3'(cos_out_bit_select) + 3'(cos_out_bias_select);
    // Both cross-feeds closed would short the two amplifiers into a loop.
    assign feed_clash = sine_to_cos_crossfeed & cos_to_sine_crossfeed;
endmodule // frsd_switch_net_model

// File: fine_reference_switch_decode_bench.sv
// Self-checking bench for the fine reference switch decoder.
// Assumes one-cycle registered outputs and reset outputs equal to the decode of count zero.
`timescale 1ns/10ps
module fine_reference_switch_decode_bench;
    import frsd_pkg::*;
    typedef struct packed
    {
        logic [11:0] cnt;
        logic [3:0] atten;
        logic [3:0] refs;
    } frsd_row_type;
    logic ref_clk;
    logic rst_n;
    logic [CNT_W-1:0] angle_count;
    logic [ATTEN_N-1:0] atten;
    logic [LADDER_W-1:0] ladder;
    logic sbit, sbias, s2c, cbit, cbias, c2s, mbit, mbias;
    frsd_quad_type quad;
    logic [2:0] ref_path_count;
    logic feed_clash;
    logic [20:0] got;
    int error_cnt = 0;
    int total_checks = 0;
    // Expected attenuation select and {sine bit, sine bias, cos bit, cos bias} per count.
    frsd_row_type rows [0:16] = '{
        {12'h000, 4'h1, 4'h2}, {12'h080, 4'h1, 4'h1}, {12'h100, 4'h2, 4'h2},
        {12'h380, 4'h8, 4'h1}, {12'h200, 4'h4, 4'h2}, {12'h3ff, 4'h8, 4'h1},
        {12'h400, 4'h8, 4'h8}, {12'h480, 4'h8, 4'h4}, {12'h500, 4'h4, 4'h8},
        {12'h780, 4'h1, 4'h4}, {12'h800, 4'h1, 4'h2}, {12'ha80, 4'h4, 4'h1},
        {12'hc00, 4'h8, 4'h8}, {12'hdff, 4'h4, 4'h4}, {12'hfff, 4'h1, 4'h4},
        {12'h07f, 4'h1, 4'h2}, {12'h655, 4'h2, 4'h8}};

    frsd_switch_decode u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .angle_count(angle_count),
        .attenuation_pair_selects(atten), .ladder_switch_enables(ladder),
        .sine_out_bit_select(sbit), .sine_out_bias_select(sbias),
        .sine_to_cos_crossfeed(s2c), .cos_out_bit_select(cbit),
        .cos_out_bias_select(cbias), .cos_to_sine_crossfeed(c2s),
        .main_summing_bit_active(mbit), .main_summing_bias_active(mbias), .quadrant(quad));
    frsd_switch_net_model u_net (.sine_out_bit_select(sbit), .sine_out_bias_select(sbias),
        .sine_to_cos_crossfeed(s2c), .cos_out_bit_select(cbit),
        .cos_out_bias_select(cbias), .cos_to_sine_crossfeed(c2s),
        .ref_path_count(ref_path_count), .feed_clash(feed_clash));

    assign got = {atten, ladder, sbit, sbias, s2c, cbit, cbias, c2s, mbit, mbias, 2'(quad)};

    function automatic logic [20:0] exp_of(input frsd_row_type r);
        logic [11:0] c;
        c = r.cnt;
        return {r.atten, c[6:0], r.refs[3], r.refs[2], ~c[10], r.refs[1], r.refs[0], c[10],
            ~c[7], c[7], c[11:10]};
    endfunction

    task automatic check_out(input logic [20:0] exp);
        total_checks++;
        if (got !== exp || ref_path_count !== 3'h1 || feed_clash !== 1'b0)
        begin
            error_cnt++;
            $display("unexpected outputs at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // The run needs under 30 cycles; an eightfold margin catches a hang.
    initial
    begin
        #5000;
        error_cnt++;
        final_report();
    end

    initial
    begin
        rst_n = 1'b0;
        angle_count = 12'hfff;
        repeat (6) @(negedge ref_clk);
        check_out(exp_of(rows[0]));
        rst_n = 1'b1;
        for (int i = 0; i < 17; i++)
        begin
            @(negedge ref_clk);
            angle_count = rows[i].cnt;
            #1;
            // Outputs must still show the previous sample until the next edge.
            if (i > 0) check_out(exp_of(rows[i - 1]));
            @(posedge ref_clk);
            #1;
            check_out(exp_of(rows[i]));
        end
        // Reset in mid-run takes effect at once, without waiting for a clock edge.
        @(negedge ref_clk);
        angle_count = 12'hc80;
        rst_n = 1'b0;
        #1;
        check_out(exp_of(rows[0]));
        @(negedge ref_clk);
        rst_n = 1'b1;
        @(posedge ref_clk);
        #1;
        check_out(exp_of({12'hc80, 4'h8, 4'h4}));
        final_report();
    end
endmodule // fine_reference_switch_decode_bench
